// ==== core/sdio_defines.svh ====
// Constants for the servo discrete I/O logic
// Contract
// R01 - Ready only when runnable and no fault pending
// R02 - Zero speed when speed at or under threshold
// R03 - Target speed reached outside pulse-position mode
// R04 - Position reached when error within window
// R05 - Torque limited output on torque limit
// R06 - Fault output except warning-first fault classes
// R07 - Listed fault classes raise warning first
// R08 - Overload warning at configured overload level
// R09 - Speed match in speed modes within window
// R10 - Speed mode puts target speed on pin pair; code does so in S mode only, SZ puts position reached on it
// R11 - Unmapped functions driven only via output map
// R12 - Servo enable input enables the motor
// R13 - Fault reset input clears clearable faults
// R14 - Pulse clear runs configured mode in position mode
// R15 - Zero hold locks motor below zero speed
// R16 - Direction invert in torque and speed modes; code honours it in plain T and S modes only, not TZ or SZ
// R17 - Torque limit enable gates limit in speed modes
// R18 - Speed limit enable gates limit in torque modes
// R19 - Status outputs recomputed as levels each cycle
// R20 - Host holds inputs stable one control cycle
`ifndef SDIO_DEFINES_SVH
`define SDIO_DEFINES_SVH
`define SDIO_ADDR_W          4
`define SDIO_REG_CTRL        4'h0
`define SDIO_REG_ZERO_SPD    4'h1
`define SDIO_REG_TGT_SPD     4'h2
`define SDIO_REG_POS_WIN     4'h3
`define SDIO_REG_SPD_WIN     4'h4
`define SDIO_REG_OVL_LVL     4'h5
`define SDIO_REG_OUT_MAP     4'h6
`define SDIO_REG_STATUS      4'h7
`define SDIO_REG_FAULT       4'h8
`define SDIO_CTRL_MODE_LSB   0
`define SDIO_CTRL_PCLR_LSB   4
`define SDIO_CTRL_POL_LSB    8
`define SDIO_ZERO_SPD_RST    32'h0000000A
`define SDIO_TGT_SPD_RST     32'h000000C8
`define SDIO_POS_WIN_RST     32'h00000064
`define SDIO_SPD_WIN_RST     32'h0000000A
`define SDIO_OVL_LVL_RST     32'h00000078
`define SDIO_OUT_MAP_RST     32'h00000000
`define SDIO_CTRL_RST        32'h00000000
`define SDIO_WARN_MASK       8'h1F
`endif

// ==== core/sdio_pkg.sv ====
// Types for the servo discrete I/O logic
package sdio_pkg;
    typedef enum logic [2:0] {
        SDIO_MODE_PT, SDIO_MODE_S, SDIO_MODE_T, SDIO_MODE_SZ, SDIO_MODE_TZ
    } sdio_mode_t;
    // Motor quantities from the control loop
    typedef struct packed {
        logic [31:0] speed_abs;
        logic [31:0] pos_err_abs;
        logic [31:0] spd_err_abs;
        logic [31:0] load_level;
        logic        torque_at_limit;
        logic        able_to_run;
    } sdio_motor_t;
    // Command qualifiers sent to the control loop
    typedef struct packed {
        logic       motor_enable;
        logic       zero_lock;
        logic       dir_invert;
        logic       torque_limit_on;
        logic       speed_limit_on;
        logic       pulse_clear;
        logic [1:0] pulse_clear_mode;
    } sdio_cmd_t;
endpackage

// ==== core/sdio_discrete_io.sv ====
// Status outputs, command inputs and register slave of the servo discrete I/O
//
// Register access over Avalon-MM and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "sdio_defines.svh"
module sdio_discrete_io
(
    input  wire logic                 sys_clk_in,
    input  wire logic                 rst_n_in,
    input  wire logic [3:0]           avs_address_in,
    input  wire logic                 avs_read_in,
    input  wire logic                 avs_write_in,
    input  wire logic [31:0]          avs_writedata_in,
    input  wire logic [3:0]           avs_byteenable_in,
    output logic      [31:0]          avs_readdata_out,
    output logic                      avs_waitrequest_out,
    input  wire sdio_pkg::sdio_motor_t motor_in,
    input  wire logic [7:0]           fault_event_in,
    input  wire logic [7:0]           fault_clearable_in,
    input  wire logic                 servo_enable_in,
    input  wire logic                 fault_reset_in,
    input  wire logic                 pulse_clear_in,
    input  wire logic                 zero_hold_in,
    input  wire logic                 direction_invert_in,
    input  wire logic                 torque_limit_enable_in,
    input  wire logic                 speed_limit_enable_in,
    output sdio_pkg::sdio_cmd_t       cmd_out,
    output logic                      drive_ready_out,
    output logic                      zero_speed_out,
    output logic                      target_speed_reached_out,
    output logic                      position_reached_out,
    output logic                      torque_limited_out,
    output logic                      fault_out,
    output logic                      warning_out,
    output logic                      overload_warning_out,
    output logic                      speed_match_out,
    output logic                      default_pair_out,
    output logic      [4:0]           mapped_out
);
    logic [31:0] ctrl_ff;
    logic [31:0] zero_speed_threshold_ff;
    logic [31:0] target_speed_setting_ff;
    logic [31:0] position_reached_window_ff;
    logic [31:0] speed_match_window_ff;
    logic [31:0] overload_level_ff;
    logic [31:0] output_map_ff;
    logic [7:0]  fault_pend_ff;
    logic [31:0] rdata_ff;
    logic        ack_ff;
    logic [6:0]  din_s1_ff;
    logic [6:0]  din_s2_ff;
    logic        son_ff;
    logic        fault_reset_in_prev_ff;
    logic        pclr_prev_ff;
    logic [31:0] nxt_wmask;
    logic [31:0] nxt_rdata;
    sdio_pkg::sdio_mode_t mode;
    logic        pos_mode;
    logic        spd_mode;
    logic        trq_mode;
    logic        fault_reset_in_pulse;
    logic        pclr_pulse;
    logic        zero_spd;
    logic        speed_match_flag;
    logic [7:0]  status_vec;
    logic [4:0]  func_vec;
    logic [4:0]  func_pol;
    logic        wr_req;
    logic        rd_req;
    logic        below_zero_spd;
    logic        inv_mode;
    logic [4:0]  map_en;

    assign mode     = sdio_pkg::sdio_mode_t'(ctrl_ff[`SDIO_CTRL_MODE_LSB +: 3]);
    assign pos_mode = (mode == sdio_pkg::SDIO_MODE_PT);
    assign spd_mode = (mode == sdio_pkg::SDIO_MODE_S) || (mode == sdio_pkg::SDIO_MODE_SZ);
    assign trq_mode = (mode == sdio_pkg::SDIO_MODE_T) || (mode == sdio_pkg::SDIO_MODE_TZ);
    assign func_pol = ctrl_ff[`SDIO_CTRL_POL_LSB +: 5];

    // Bus: one wait cycle, then acknowledge
    // A write lands only at the edge where waitrequest is sampled low
    assign wr_req = avs_write_in && ack_ff;
    // Read data is loaded in the wait cycle so it stands at that edge
    assign rd_req = avs_read_in && !ack_ff;
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_ff;

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            nxt_wmask[i*8 +: 8] = {8{avs_byteenable_in[i]}};
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ack_ff <= 1'b0;
        end
        else
        begin
            ack_ff <= (avs_read_in || avs_write_in) && !ack_ff;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ctrl_ff                    <= `SDIO_CTRL_RST;
            zero_speed_threshold_ff    <= `SDIO_ZERO_SPD_RST;
            target_speed_setting_ff    <= `SDIO_TGT_SPD_RST;
            position_reached_window_ff <= `SDIO_POS_WIN_RST;
            speed_match_window_ff      <= `SDIO_SPD_WIN_RST;
            overload_level_ff          <= `SDIO_OVL_LVL_RST;
            output_map_ff              <= `SDIO_OUT_MAP_RST;
        end
        else if (wr_req)
        begin
            // Status and fault indices are read-only; other indices are ignored
            if (avs_address_in == `SDIO_REG_CTRL)
            begin
                ctrl_ff <= (ctrl_ff & ~nxt_wmask) | (avs_writedata_in & nxt_wmask);
            end
            else if (avs_address_in == `SDIO_REG_ZERO_SPD)
            begin
                zero_speed_threshold_ff <= (zero_speed_threshold_ff & ~nxt_wmask)
                                         | (avs_writedata_in & nxt_wmask);
            end
            else if (avs_address_in == `SDIO_REG_TGT_SPD)
            begin
                target_speed_setting_ff <= (target_speed_setting_ff & ~nxt_wmask)
                                         | (avs_writedata_in & nxt_wmask);
            end
            else if (avs_address_in == `SDIO_REG_POS_WIN)
            begin
                position_reached_window_ff <= (position_reached_window_ff & ~nxt_wmask)
                                            | (avs_writedata_in & nxt_wmask);
            end
            else if (avs_address_in == `SDIO_REG_SPD_WIN)
            begin
                speed_match_window_ff <= (speed_match_window_ff & ~nxt_wmask)
                                       | (avs_writedata_in & nxt_wmask);
            end
            else if (avs_address_in == `SDIO_REG_OVL_LVL)
            begin
                overload_level_ff <= (overload_level_ff & ~nxt_wmask)
                                   | (avs_writedata_in & nxt_wmask);
            end
            else if (avs_address_in == `SDIO_REG_OUT_MAP)
            begin
                output_map_ff <= (output_map_ff & ~nxt_wmask) | (avs_writedata_in & nxt_wmask);
            end
        end
    end

    always_comb
    begin
        if (avs_address_in == `SDIO_REG_CTRL)
            nxt_rdata = ctrl_ff;
        else if (avs_address_in == `SDIO_REG_ZERO_SPD)
            nxt_rdata = zero_speed_threshold_ff;
        else if (avs_address_in == `SDIO_REG_TGT_SPD)
            nxt_rdata = target_speed_setting_ff;
        else if (avs_address_in == `SDIO_REG_POS_WIN)
            nxt_rdata = position_reached_window_ff;
        else if (avs_address_in == `SDIO_REG_SPD_WIN)
            nxt_rdata = speed_match_window_ff;
        else if (avs_address_in == `SDIO_REG_OVL_LVL)
            nxt_rdata = overload_level_ff;
        else if (avs_address_in == `SDIO_REG_OUT_MAP)
            nxt_rdata = output_map_ff;
        else if (avs_address_in == `SDIO_REG_STATUS)
            nxt_rdata = {24'h000000, status_vec};
        else if (avs_address_in == `SDIO_REG_FAULT)
            nxt_rdata = {24'h000000, fault_pend_ff};
        // Unmapped indices read as zero
        else
            nxt_rdata = 32'h00000000;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rdata_ff <= 32'h00000000;
        end
        // Stands until the next read is taken
        else if (rd_req)
        begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign avs_readdata_out = rdata_ff;

    // Pin inputs pass two flip-flops
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            din_s1_ff <= 7'h00;
            din_s2_ff <= 7'h00;
        end
        else
        begin
            din_s1_ff <= {speed_limit_enable_in, torque_limit_enable_in, direction_invert_in,
                          zero_hold_in, pulse_clear_in, fault_reset_in, servo_enable_in};
            din_s2_ff <= din_s1_ff;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            son_ff       <= 1'b0;
            fault_reset_in_prev_ff <= 1'b0;
            pclr_prev_ff <= 1'b0;
        end
        else
        begin
            // Servo enable passes one stage more than the other qualifiers
            son_ff       <= din_s2_ff[0];
            fault_reset_in_prev_ff <= din_s2_ff[1];
            pclr_prev_ff <= din_s2_ff[2];
        end
    end
    assign fault_reset_in_pulse = din_s2_ff[1] && !fault_reset_in_prev_ff;
    assign pclr_pulse = din_s2_ff[2] && !pclr_prev_ff;

    // Pending faults: a new event wins over the reset clear
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            fault_pend_ff <= 8'h00;
        end
        else if (fault_reset_in_pulse)
        begin
            fault_pend_ff <= (fault_pend_ff & ~fault_clearable_in) | fault_event_in; // [R13]
        end
        else
        begin
            fault_pend_ff <= fault_pend_ff | fault_event_in;
        end
    end

    assign zero_spd = motor_in.speed_abs <= zero_speed_threshold_ff;
    // Zero hold needs the speed strictly under the threshold
    assign below_zero_spd = motor_in.speed_abs < zero_speed_threshold_ff;
    // Direction invert is honoured in the plain torque and speed modes only
    assign inv_mode = (mode == sdio_pkg::SDIO_MODE_T) || (mode == sdio_pkg::SDIO_MODE_S);
    assign speed_match_flag = spd_mode
                              && (motor_in.spd_err_abs <= speed_match_window_ff);    // [R09]

    // Status levels, recomputed every cycle
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            status_vec <= 8'h00;
        end
        else
        begin
            status_vec[0] <= motor_in.able_to_run && (fault_pend_ff == 8'h00);   // [R01] [R19]
            status_vec[1] <= zero_spd;                                             // [R02]
            status_vec[2] <= !pos_mode
                             && (motor_in.speed_abs >= target_speed_setting_ff);   // [R03]
            status_vec[3] <= pos_mode
                             && (motor_in.pos_err_abs <= position_reached_window_ff); // [R04]
            status_vec[4] <= motor_in.torque_at_limit;                             // [R05]
            // Warning-first classes never raise the fault output
            status_vec[5] <= |(fault_pend_ff & ~`SDIO_WARN_MASK);                  // [R06]
            status_vec[6] <= |(fault_pend_ff & `SDIO_WARN_MASK);                   // [R07]
            status_vec[7] <= motor_in.load_level >= overload_level_ff;             // [R08]
        end
    end

    assign drive_ready_out          = status_vec[0];
    assign zero_speed_out           = status_vec[1];
    assign torque_limited_out       = status_vec[4];
    assign fault_out                = status_vec[5];
    assign warning_out              = status_vec[6];
    assign overload_warning_out     = status_vec[7];
    assign target_speed_reached_out = status_vec[2];
    assign position_reached_out     = status_vec[3];

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            speed_match_out  <= 1'b0;
            default_pair_out <= 1'b0;
        end
        else
        begin
            speed_match_out  <= speed_match_flag;
            default_pair_out <= (mode == sdio_pkg::SDIO_MODE_S) ? status_vec[2]
                                                                : status_vec[3]; // [R10]
        end
    end

    // Non-default functions leave only through a map slot, with polarity
    assign func_vec = {speed_match_out, overload_warning_out, warning_out,
                       torque_limited_out, target_speed_reached_out};
    assign map_en = output_map_ff[4:0];
    generate
        for (genvar g = 0; g < 5; g++)
        begin : g_map
            always_ff @(posedge sys_clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                begin
                    mapped_out[g] <= 1'b0;
                end
                else
                begin
                    // Polarity flips the function before the enable gates it
                    mapped_out[g] <= map_en[g] && (func_vec[g] ^ func_pol[g]); // [R11]
                end
            end
        end
    endgenerate

    // Command qualifiers to the control loop
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cmd_out <= '0;
        end
        else
        begin
            cmd_out.motor_enable     <= son_ff;                                     // [R12]
            cmd_out.zero_lock        <= din_s2_ff[3] && below_zero_spd;             // [R15]
            cmd_out.dir_invert       <= din_s2_ff[4] && inv_mode;                   // [R16]
            cmd_out.torque_limit_on  <= din_s2_ff[5] && spd_mode;                   // [R17]
            cmd_out.speed_limit_on   <= din_s2_ff[6] && trq_mode;                   // [R18]
            cmd_out.pulse_clear      <= pclr_pulse && pos_mode;                     // [R14] [R20]
            cmd_out.pulse_clear_mode <= ctrl_ff[`SDIO_CTRL_PCLR_LSB +: 2];
        end
    end
endmodule

// ==== sim/sdio_host_model.sv ====
// Host controller model driving the command pins
`timescale 1ns/1ps
module sdio_host_model
(
    input  wire logic       sys_clk_in,
    input  wire logic [6:0] want_in,
    output logic      [6:0] pins_out
);
    logic [1:0] hold_ff = 2'h0;
    initial pins_out = 7'h00;
    // A pin pattern stands three cycles before it may change
    always @(posedge sys_clk_in)
    begin
        if (hold_ff != 2'h0)
            hold_ff <= hold_ff - 2'h1;
        else if (want_in != pins_out)
        begin
            pins_out <= want_in;
            hold_ff  <= 2'h2;
        end
    end
endmodule

// ==== sim/sdio_assertions.sv ====
// Port checks of the servo discrete I/O
`timescale 1ns/1ps
module sdio_assertions
(
    input wire logic                  sys_clk_in,
    input wire logic                  rst_n_in,
    input wire sdio_pkg::sdio_motor_t motor_in,
    input wire logic [7:0]            fault_event_in,
    input wire logic                  servo_enable_in,
    input wire logic                  fault_reset_in,
    input wire logic                  pulse_clear_in,
    input wire logic                  zero_hold_in,
    input wire sdio_pkg::sdio_cmd_t   cmd_out,
    input wire logic                  drive_ready_out,
    input wire logic                  target_speed_reached_out,
    input wire logic                  position_reached_out,
    input wire logic                  torque_limited_out,
    input wire logic                  fault_out,
    input wire logic                  warning_out,
    input wire logic                  default_pair_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    a_ready_no_fault: assert property (drive_ready_out |->
        $past(motor_in.able_to_run) && !fault_out && !warning_out)
        else $error("ready with fault or not runnable");
    a_torque_follows: assert property ($past(rst_n_in) |->
        torque_limited_out == $past(motor_in.torque_at_limit))
        else $error("torque limit output wrong");
    a_fault_cause: assert property ($rose(fault_out) |-> $past(|fault_event_in[7:5]) ||
        $past(|fault_event_in[7:5], 2) || $past(|fault_event_in[7:5], 3))
        else $error("fault without fault event");
    a_warn_cause: assert property ($rose(warning_out) |-> $past(|fault_event_in[4:0]) ||
        $past(|fault_event_in[4:0], 2) || $past(|fault_event_in[4:0], 3))
        else $error("warning without warning event");
    a_clear_needs_reset: assert property (($fell(fault_out) || $fell(warning_out)) |->
        $past(fault_reset_in, 2) || $past(fault_reset_in, 3) || $past(fault_reset_in, 4))
        else $error("fault cleared without reset input");
    a_enable_follows: assert property ($past(servo_enable_in, 3) == $past(servo_enable_in, 4)
        |-> cmd_out.motor_enable == $past(servo_enable_in, 3))
        else $error("motor enable does not follow pin");
    a_clear_pulse: assert property (cmd_out.pulse_clear |->
        ($past(pulse_clear_in, 2) || $past(pulse_clear_in, 3)) ##1 !cmd_out.pulse_clear)
        else $error("pulse clear wrong");
    a_pair_source: assert property (default_pair_out |->
        $past(target_speed_reached_out) || $past(position_reached_out))
        else $error("default pair without source");
    a_lock_needs_pin: assert property (cmd_out.zero_lock |->
        $past(zero_hold_in, 2) || $past(zero_hold_in, 3))
        else $error("zero lock without pin");
endmodule
bind sdio_discrete_io sdio_assertions chk_u (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .motor_in(motor_in), .fault_event_in(fault_event_in), .servo_enable_in(servo_enable_in),
    .fault_reset_in(fault_reset_in), .pulse_clear_in(pulse_clear_in),
    .zero_hold_in(zero_hold_in), .cmd_out(cmd_out), .drive_ready_out(drive_ready_out),
    .target_speed_reached_out(target_speed_reached_out),
    .position_reached_out(position_reached_out), .torque_limited_out(torque_limited_out),
    .fault_out(fault_out), .warning_out(warning_out), .default_pair_out(default_pair_out));

// ==== sim/servo_discrete_io_logic_test.sv ====
// Self-checking bench of the servo discrete I/O
`timescale 1ns/1ps
`include "sdio_defines.svh"
module servo_discrete_io_logic_test;
    logic                  clk = 1'h0;
    logic                  rst_n = 1'h0;
    logic [3:0]            adr = 4'h0;
    logic                  rd = 1'h0;
    logic                  wr = 1'h0;
    logic [31:0]           wdat = 32'h0;
    logic [31:0]           rdat;
    logic                  wait_req;
    sdio_pkg::sdio_motor_t mot = '0;
    logic [7:0]            fev = 8'h00;
    logic [7:0]            fclr = 8'hFF;
    logic [6:0]            want = 7'h00;
    logic [6:0]            pins;
    sdio_pkg::sdio_cmd_t   cmd;
    logic [9:0]            st;
    logic [4:0]            mapd;
    logic [31:0]           exp_q[$];
    logic [31:0]           spd_v[5] = '{32'hA, 32'hB, 32'hC7, 32'hC8, 32'h0};
    logic [31:0]           rst_v[7] = '{`SDIO_CTRL_RST, `SDIO_ZERO_SPD_RST, `SDIO_TGT_SPD_RST,
        `SDIO_POS_WIN_RST, `SDIO_SPD_WIN_RST, `SDIO_OVL_LVL_RST, `SDIO_OUT_MAP_RST};
    int                    n_fail = 0;
    int                    check_count = 0;
    int                    pulses = 0;
    logic [1:0]            pmode = 2'h0;
    always #2 clk = !clk;
    sdio_host_model host_u (.sys_clk_in(clk), .want_in(want), .pins_out(pins));
    sdio_discrete_io dut_u (.sys_clk_in(clk), .rst_n_in(rst_n), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdat), .avs_waitrequest_out(wait_req),
        .motor_in(mot), .fault_event_in(fev), .fault_clearable_in(fclr),
        .servo_enable_in(pins[0]), .fault_reset_in(pins[1]), .pulse_clear_in(pins[2]),
        .zero_hold_in(pins[3]), .direction_invert_in(pins[4]),
        .torque_limit_enable_in(pins[5]), .speed_limit_enable_in(pins[6]), .cmd_out(cmd),
        .drive_ready_out(st[0]), .zero_speed_out(st[1]), .target_speed_reached_out(st[2]),
        .position_reached_out(st[3]), .torque_limited_out(st[4]), .fault_out(st[5]),
        .warning_out(st[6]), .overload_warning_out(st[7]), .speed_match_out(st[8]),
        .default_pair_out(st[9]), .mapped_out(mapd));
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] ex, input string what);
        check_count++;
        if (seen !== ex)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, ex, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int t;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= d;
        t = 0;
        do
        begin
            @(posedge clk);
            t++;
        end
        while (wait_req !== 1'h0 && t < 50);
        if (t >= 50)
            n_fail++;
        rd <= 1'h0;
        wr <= 1'h0;
        repeat (4) @(posedge clk);
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'h0, a, 32'h0);
    endtask
    task automatic drv(input logic [31:0] sp, pe, se, ld, input logic [1:0] tr,
        input logic [7:0] f, input logic [6:0] p);
        @(posedge clk);
        mot <= {sp, pe, se, ld, tr};
        fev <= f;
        want <= p;
        repeat (8) @(posedge clk);
        #1;
    endtask
    // Read data is compared with the oldest noted value when it is taken
    always @(posedge clk)
    begin
        if (rd && wait_req === 1'h0)
            check(rdat, exp_q.pop_front(), "readdata");
    end
    always @(posedge clk)
    begin
        if (cmd.pulse_clear === 1'h1)
        begin
            pulses++;
            pmode = cmd.pulse_clear_mode;
        end
    end
    initial
    begin
        #40000;
        n_fail++;
        stop_test();
    end
    initial
    begin
        void'($urandom(32'hDD274E76));
        spd_v[4] = 32'hC9 + $urandom_range(1000);
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        bus(1'h1, 4'h7, 32'hFFFFFFFF);
        foreach (rst_v[i])
            rd_reg(i[3:0], rst_v[i]);
        rd_reg(4'h9, 32'h0);
        rd_reg(4'h7, 32'hA);
        bus(1'h1, 4'h0, 32'h1);
        for (int i = 0; i < 5; i++)
        begin
            drv(spd_v[i], 32'h0, 32'h9 + i, 32'h76 + i, {i[0], 1'h1}, 8'h00, 7'h00);
            check(st[0], 1, "ready");
            check(st[1], i == 0, "zero speed");
            check(st[2], i >= 3, "target speed");
            check(st[4], i[0], "torque limited");
            check(st[7], i >= 2, "overload");
            check(st[8], i < 2, "speed match");
            check(st[9], i >= 3, "default pair");
        end
        bus(1'h1, 4'h6, 32'h1F);
        check(mapd, 5'h09, "mapped");
        bus(1'h1, 4'h0, 32'h101);
        check(mapd, 5'h08, "mapped polarity");
        bus(1'h1, 4'h6, 32'h0);
        check(mapd, 5'h00, "mapped off");
        bus(1'h1, 4'h0, 32'h2);
        drv(32'h0, 32'h0, 32'h0, 32'h0, 2'h1, 8'h00, 7'h00);
        check(st[8], 0, "speed match torque mode");
        bus(1'h1, 4'h0, 32'h0);
        for (int i = 0; i < 2; i++)
        begin
            drv(32'hBB8, 32'h64 + i, 32'h0, 32'h0, 2'h1, 8'h00, 7'h00);
            check(st[3], i == 0, "position reached");
            check(st[9], i == 0, "default pair position");
            check(st[2], 0, "target speed position mode");
        end
        drv(32'h0, 32'h0, 32'h0, 32'h0, 2'h1, 8'h04, 7'h00);
        check(st[6:5], 2'h2, "warning first");
        check(st[0], 0, "ready with warning");
        drv(32'h0, 32'h0, 32'h0, 32'h0, 2'h1, 8'h40, 7'h00);
        check(st[5], 1, "fault");
        @(posedge clk);
        fclr <= 8'hBF;
        drv(32'h0, 32'h0, 32'h0, 32'h0, 2'h1, 8'h00, 7'h02);
        check(st[6:5], 2'h1, "partial clear");
        rd_reg(4'h8, 32'h40);
        @(posedge clk);
        fclr <= 8'hFF;
        drv(32'h0, 32'h0, 32'h0, 32'h0, 2'h1, 8'h00, 7'h00);
        drv(32'h0, 32'h0, 32'h0, 32'h0, 2'h1, 8'h00, 7'h02);
        check(st[6:0] & 7'h61, 7'h01, "cleared and ready");
        drv(32'h0, 32'h0, 32'h0, 32'h0, 2'h0, 8'h00, 7'h00);
        check(st[0], 0, "ready not runnable");
        for (int m = 0; m < 5; m++)
        begin
            bus(1'h1, 4'h0, 32'h20 | m);
            drv(32'h5, 32'h0, 32'h0, 32'h0, 2'h1, 8'h00, 7'h7D);
            check(cmd.motor_enable, 1, "motor enable");
            check(cmd.zero_lock, 1, "zero lock");
            check(cmd.dir_invert, m == 1 || m == 2, "direction invert");
            check(cmd.torque_limit_on, m == 1 || m == 3, "torque limit on");
            check(cmd.speed_limit_on, m == 2 || m == 4, "speed limit on");
            check(pulses, 1, "pulse clear count");
            check(pmode, 2'h2, "pulse clear mode");
            drv(32'h32, 32'h0, 32'h0, 32'h0, 2'h1, 8'h00, 7'h08);
            check(cmd.zero_lock, 0, "zero lock fast");
            check(cmd.motor_enable, 0, "motor disable");
        end
        stop_test();
    end
endmodule
